// ===== verilog/lpm_seq_pkg.sv
// constants and types for the low-power mode sequencer
// Notes on behaviour
// - In the two shutdown modes only real-time clock or port events wake the device.
// - A watchdog soft reset during mode 2, 3 or 4 sets the memory low-power power bit again.
// - With that bit clear, wake-up outside the shutdown modes lasts the mode's wake time plus the memory wake time.
// - Module oscillator clock requests come from the converter and from I2C with timeout on.
// - Subsystem clock requests come from converter, I2C/SPI master, UART and sensor timing.
// - Requests from the CPU or DMA are synchronous and never overlap a mode change.
// - Clearing both memory power bits puts the memory in its inactive state.
// - Clearing the reset-pin resistor enable also drops the test-clock pin pull-down.
// - The resistor direction bit selects pull-up or pull-down on the reset pin.
// - A watchdog control write with a wrong password causes a soft reset.
// - Modes are entered on ISR exit and on direct status-register writes.
package lpm_seq_pkg;
    // ------------------------------------------------------------
    // modes and states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        mode_active = 3'h0,
        mode_lpm0 = 3'h1,
        mode_lpm1 = 3'h2,
        mode_lpm2 = 3'h3,
        mode_lpm3 = 3'h4,
        mode_lpm4 = 3'h5,
        mode_shutdown_with_clock = 3'h6,
        mode_full_shutdown = 3'h7
    } power_mode_t;
    typedef enum logic [1:0] {
        st_run = 2'h0,
        st_sleep = 2'h1,
        st_wake = 2'h3
    } seq_state_t;
    // ------------------------------------------------------------
    // peripheral clock requests
    // ------------------------------------------------------------
    typedef struct packed {
        logic adc;
        logic i2c_mode;
        logic i2c_master;
        logic i2c_timeout_en;
        logic spi_master;
        logic uart_mode;
        logic serial;
        logic sensor_tsm;
    } clk_req_t;
    // ------------------------------------------------------------
    // timing and reset values
    // ------------------------------------------------------------
    localparam int clk_mhz = 100;
    localparam int wake_lpm_ns = 100;
    localparam int wake_mem_ns = 100;
    localparam logic [15:0] wake_lpm_cycles = 16'((wake_lpm_ns * clk_mhz + 999) / 1000);
    localparam logic [15:0] wake_mem_cycles = 16'((wake_mem_ns * clk_mhz + 999) / 1000);
    localparam logic [7:0] wdt_password = 8'h5a;
    localparam logic reset_mem_power = 1'b1;
    localparam logic reset_mem_lowpower_power = 1'b1;
    localparam logic reset_pin_resistor_enable_init = 1'b1;
    localparam logic reset_pin_resistor_direction_init = 1'b1;
endpackage

// ===== verilog/low_power_mode_sequencer.sv
// low-power mode sequencer with clock request routing and pin resistor control
`timescale 1ns/100ps
`default_nettype none
module low_power_mode_sequencer (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sr_write,
    input wire logic isr_exit,
    input wire lpm_seq_pkg::power_mode_t req_mode,
    input wire logic irq_any,
    input wire logic irq_rtc,
    input wire logic irq_port,
    input wire logic wdt_soft_reset,
    input wire logic wdt_ctl_write,
    input wire logic [7:0] wdt_ctl_password,
    input wire logic mem_write,
    input wire logic mem_power_enable_wr,
    input wire logic mem_lowpower_power_wr,
    input wire logic pin_cfg_write,
    input wire logic reset_pin_resistor_enable_wr,
    input wire logic reset_pin_resistor_direction_wr,
    input wire lpm_seq_pkg::clk_req_t periph_req_async,
    input wire logic cpu_dma_req,
    output lpm_seq_pkg::power_mode_t cur_mode,
    output logic wake_done,
    output logic soft_reset,
    output logic mem_power_enable_bit,
    output logic mem_lowpower_power_bit,
    output logic mem_inactive,
    output logic module_oscillator_clock_req,
    output logic subsystem_clock_req,
    output logic reset_pin_pull_en,
    output logic reset_pin_pull_up,
    output logic test_twowire_clock_pin_pulldown_en
);
    // ------------------------------------------------------------
    // synchronise asynchronous requests
    // ------------------------------------------------------------
    lpm_seq_pkg::clk_req_t req_meta;
    lpm_seq_pkg::clk_req_t req_sync;
    // sequencer state and wake countdown
    lpm_seq_pkg::seq_state_t state;
    logic [15:0] wake_count;
    logic [15:0] wake_load;
    logic in_deep;
    logic next_module_oscillator_clock_req;
    logic next_subsystem_clock_req;

    // ------------------------------------------------------------
    // mode decoding
    // ------------------------------------------------------------
    // modes where a watchdog reset restores the memory low-power power bit
    function automatic logic is_deep_mode(input lpm_seq_pkg::power_mode_t m);
        return (m == lpm_seq_pkg::mode_lpm2) | (m == lpm_seq_pkg::mode_lpm3)
            | (m == lpm_seq_pkg::mode_lpm4);
    endfunction

    // shutdown modes wake only on the real-time clock or a port
    function automatic logic is_shutdown_mode(input lpm_seq_pkg::power_mode_t m);
        return (m == lpm_seq_pkg::mode_shutdown_with_clock)
            | (m == lpm_seq_pkg::mode_full_shutdown);
    endfunction

    // two-stage synchroniser for peripheral requests
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            req_meta <= '0;
            req_sync <= '0;
        end else begin
            req_meta <= periph_req_async;
            req_sync <= req_meta;
        end
    end

    // ------------------------------------------------------------
    // clock request routing
    // ------------------------------------------------------------
    // request terms; cpu/dma request is already on clk
    // asynchronous edges only reach this after both synchroniser flops,
    // so a request edge never lands inside a mode change decision
    always_comb begin
        next_module_oscillator_clock_req = req_sync.adc
            | (req_sync.i2c_mode & req_sync.i2c_timeout_en);
        next_subsystem_clock_req = req_sync.adc | req_sync.sensor_tsm
            | (req_sync.serial & (req_sync.i2c_master | req_sync.spi_master
            | req_sync.uart_mode))
            | cpu_dma_req;
    end

    // registered request outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            module_oscillator_clock_req <= 1'b0;
            subsystem_clock_req <= 1'b0;
        end else begin
            module_oscillator_clock_req <= next_module_oscillator_clock_req;
            subsystem_clock_req <= next_subsystem_clock_req;
        end
    end

    // ------------------------------------------------------------
    // soft reset from watchdog
    // ------------------------------------------------------------
    // wrong password write resets in any watchdog mode
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= wdt_soft_reset
                | (wdt_ctl_write & (wdt_ctl_password != lpm_seq_pkg::wdt_password));
        end
    end

    // ------------------------------------------------------------
    // memory power bits
    // ------------------------------------------------------------
    assign in_deep = is_deep_mode(cur_mode);

    // software writes, soft reset in deep modes restores the low-power bit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mem_power_enable_bit <= lpm_seq_pkg::reset_mem_power;
            mem_lowpower_power_bit <= lpm_seq_pkg::reset_mem_lowpower_power;
        end else if (soft_reset) begin
            mem_power_enable_bit <= lpm_seq_pkg::reset_mem_power;
            if (in_deep) begin
                mem_lowpower_power_bit <= 1'b1;
            end
        end else if (mem_write) begin
            mem_power_enable_bit <= mem_power_enable_wr;
            mem_lowpower_power_bit <= mem_lowpower_power_wr;
        end
    end

    // inactive when both bits are clear
    assign mem_inactive = ~mem_power_enable_bit & ~mem_lowpower_power_bit;

    // ------------------------------------------------------------
    // mode sequencing
    // ------------------------------------------------------------
    // wake time, stretched by the memory wake time when its power bit is clear, except in the shutdown modes
    always_comb begin
        if (is_shutdown_mode(cur_mode) || mem_lowpower_power_bit) begin
            wake_load = lpm_seq_pkg::wake_lpm_cycles;
        end else begin
            wake_load = 16'(lpm_seq_pkg::wake_lpm_cycles
                + lpm_seq_pkg::wake_mem_cycles);
        end
    end

    // entry on isr exit or status write, wake on allowed sources
    // a watchdog reset while asleep drops straight back to active
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= lpm_seq_pkg::st_run;
            cur_mode <= lpm_seq_pkg::mode_active;
            wake_count <= '0;
            wake_done <= 1'b0;
        end else begin
            wake_done <= 1'b0;
            unique case (state)
                lpm_seq_pkg::st_run: begin
                    if ((sr_write | isr_exit) && req_mode != lpm_seq_pkg::mode_active) begin
                        cur_mode <= req_mode;
                        state <= lpm_seq_pkg::st_sleep;
                    end
                end
                lpm_seq_pkg::st_sleep: begin
                    if (soft_reset) begin
                        cur_mode <= lpm_seq_pkg::mode_active;
                        state <= lpm_seq_pkg::st_run;
                    end else if (is_shutdown_mode(cur_mode)) begin
                        // other interrupts cannot wake a shutdown mode
                        if (irq_rtc | irq_port) begin
                            state <= lpm_seq_pkg::st_wake;
                            wake_count <= wake_load;
                        end
                    end else if (irq_any | irq_rtc | irq_port) begin
                        state <= lpm_seq_pkg::st_wake;
                        wake_count <= wake_load;
                    end
                end
                lpm_seq_pkg::st_wake: begin
                    if (wake_count <= 16'h0001) begin
                        cur_mode <= lpm_seq_pkg::mode_active;
                        state <= lpm_seq_pkg::st_run;
                        wake_done <= 1'b1;
                    end else begin
                        wake_count <= wake_count - 16'h0001;
                    end
                end
                default: begin
                    state <= lpm_seq_pkg::st_run;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // reset pin resistor control
    // ------------------------------------------------------------
    // enable also governs the test clock pin pull-down
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reset_pin_pull_en <= lpm_seq_pkg::reset_pin_resistor_enable_init;
            reset_pin_pull_up <= lpm_seq_pkg::reset_pin_resistor_direction_init;
        end else if (pin_cfg_write) begin
            reset_pin_pull_en <= reset_pin_resistor_enable_wr;
            reset_pin_pull_up <= reset_pin_resistor_direction_wr;
        end
    end

    assign test_twowire_clock_pin_pulldown_en = reset_pin_pull_en;
endmodule
`default_nettype wire

// ===== test/periph_model.sv
// peripheral side model issuing clock requests
`timescale 1ns/100ps
`default_nettype none
module periph_model (
    input wire logic clk,
    input wire lpm_seq_pkg::clk_req_t want,
    input wire logic want_cpu,
    output lpm_seq_pkg::clk_req_t req,
    output logic cpu_req
);
    initial req = '0;
    // peripheral requests move off the clock grid
    always @(want) req <= #3.3 want;
    // cpu and dma requests move only on the clock
    always_ff @(posedge clk) cpu_req <= want_cpu;
endmodule
`default_nettype wire

// ===== test/lpm_seq_monitor.sv
// assertion checker on the sequencer ports
`timescale 1ns/100ps
`default_nettype none
module lpm_seq_monitor (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sr_write,
    input wire logic isr_exit,
    input wire logic wdt_soft_reset,
    input wire logic wdt_ctl_write,
    input wire logic mem_write,
    input wire logic mem_power_enable_wr,
    input wire logic mem_lowpower_power_wr,
    input wire logic pin_cfg_write,
    input wire logic soft_reset,
    input wire logic reset_pin_resistor_enable_wr,
    input wire logic reset_pin_resistor_direction_wr,
    input wire logic wake_done,
    input wire logic mem_lowpower_power_bit,
    input wire logic mem_inactive,
    input wire logic module_oscillator_clock_req,
    input wire logic subsystem_clock_req,
    input wire logic reset_pin_pull_up,
    input wire logic test_twowire_clock_pin_pulldown_en,
    input wire logic [7:0] wdt_ctl_password,
    input wire lpm_seq_pkg::power_mode_t req_mode,
    input wire lpm_seq_pkg::power_mode_t cur_mode,
    input wire lpm_seq_pkg::clk_req_t periph_req_async
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic quiet;
    // no watchdog event in flight
    assign quiet = !wdt_soft_reset && !wdt_ctl_write && !soft_reset;
    property p_entry; (sr_write || isr_exit) && quiet && !wake_done && req_mode != 3'h0
        && cur_mode == lpm_seq_pkg::mode_active |=> cur_mode == $past(req_mode); endproperty
    a_entry: assert property (p_entry) else $error("mode entry");
    property p_bad_pw;
        wdt_ctl_write && wdt_ctl_password != lpm_seq_pkg::wdt_password |=> soft_reset; endproperty
    a_bad_pw: assert property (p_bad_pw) else $error("bad password");
    property p_restore; soft_reset && (cur_mode == lpm_seq_pkg::mode_lpm2
        || cur_mode == lpm_seq_pkg::mode_lpm3 || cur_mode == lpm_seq_pkg::mode_lpm4)
        |-> ##[1:2] mem_lowpower_power_bit; endproperty
    a_restore: assert property (p_restore) else $error("power bit restore");
    property p_inactive; mem_write && quiet && !mem_power_enable_wr && !mem_lowpower_power_wr
        |=> mem_inactive; endproperty
    a_inactive: assert property (p_inactive) else $error("memory inactive");
    property p_pin_en; pin_cfg_write |=>
        test_twowire_clock_pin_pulldown_en == $past(reset_pin_resistor_enable_wr); endproperty
    a_pin_en: assert property (p_pin_en) else $error("pull-down enable");
    property p_pin_dir; pin_cfg_write |=>
        reset_pin_pull_up == $past(reset_pin_resistor_direction_wr); endproperty
    a_pin_dir: assert property (p_pin_dir) else $error("pull direction");
    property p_adc; periph_req_async.adc |->
        ##[2:4] module_oscillator_clock_req && subsystem_clock_req; endproperty
    a_adc: assert property (p_adc) else $error("converter requests");
    property p_sensor; periph_req_async.sensor_tsm |-> ##[2:4] subsystem_clock_req; endproperty
    a_sensor: assert property (p_sensor) else $error("sensor request");
    c_wake: cover property (wake_done);
    c_reset: cover property (soft_reset ##1 mem_lowpower_power_bit);
    c_shut: cover property (cur_mode == lpm_seq_pkg::mode_full_shutdown);
endmodule
bind low_power_mode_sequencer lpm_seq_monitor i_mon (.*);
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the low-power mode sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk = 0, resetn = 0, sr_write = 0, isr_exit = 0, irq_any = 0, irq_rtc = 0, irq_port = 0;
    logic wdt_soft_reset = 0, wdt_ctl_write = 0, mem_write = 0, pin_cfg_write = 0, want_cpu = 0;
    logic mem_power_enable_wr = 1, mem_lowpower_power_wr = 1, cpu_req, wake_done, soft_reset;
    logic reset_pin_resistor_enable_wr = 1, reset_pin_resistor_direction_wr = 1, mem_inactive;
    logic mem_power_enable_bit, mem_lowpower_power_bit, reset_pin_pull_en, reset_pin_pull_up;
    logic module_oscillator_clock_req, subsystem_clock_req, test_twowire_clock_pin_pulldown_en;
    logic [7:0] wdt_ctl_password = 8'h00;
    lpm_seq_pkg::power_mode_t req_mode = lpm_seq_pkg::mode_active, cur_mode;
    lpm_seq_pkg::clk_req_t want = '0, req;
    int err_count = 0, compares = 0, n_set, n_clr;
    always #5 clk = ~clk;
    low_power_mode_sequencer i_dut (
        .clk(clk), .resetn(resetn), .sr_write(sr_write), .isr_exit(isr_exit),
        .req_mode(req_mode), .irq_any(irq_any), .irq_rtc(irq_rtc), .irq_port(irq_port),
        .wdt_soft_reset(wdt_soft_reset), .wdt_ctl_write(wdt_ctl_write),
        .wdt_ctl_password(wdt_ctl_password), .mem_write(mem_write),
        .mem_power_enable_wr(mem_power_enable_wr),
        .mem_lowpower_power_wr(mem_lowpower_power_wr),
        .pin_cfg_write(pin_cfg_write),
        .reset_pin_resistor_enable_wr(reset_pin_resistor_enable_wr),
        .reset_pin_resistor_direction_wr(reset_pin_resistor_direction_wr),
        .periph_req_async(req), .cpu_dma_req(cpu_req), .cur_mode(cur_mode),
        .wake_done(wake_done), .soft_reset(soft_reset),
        .mem_power_enable_bit(mem_power_enable_bit),
        .mem_lowpower_power_bit(mem_lowpower_power_bit), .mem_inactive(mem_inactive),
        .module_oscillator_clock_req(module_oscillator_clock_req),
        .subsystem_clock_req(subsystem_clock_req), .reset_pin_pull_en(reset_pin_pull_en),
        .reset_pin_pull_up(reset_pin_pull_up),
        .test_twowire_clock_pin_pulldown_en(test_twowire_clock_pin_pulldown_en)
    );
    periph_model i_periph (
        .clk(clk), .want(want), .want_cpu(want_cpu), .req(req), .cpu_req(cpu_req)
    );
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) err_count++;
        if (got !== exp) $display("ERROR %s expected %h seen %h", name, exp, got);
    endtask
    task automatic stop_test;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic enter(input lpm_seq_pkg::power_mode_t m, input logic isr);
        req_mode = m;
        {sr_write, isr_exit} = {!isr, isr};
        tick();
        {sr_write, isr_exit} = 2'h0;
        tick();
        cmp("cur_mode", 16'(m), 16'(cur_mode));
    endtask
    task automatic mem(input logic en, input logic lp);
        {mem_power_enable_wr, mem_lowpower_power_wr, mem_write} = {en, lp, 1'b1};
        tick();
        mem_write = 0;
        tick();
    endtask
    task automatic wait_wake(output int n);
        for (n = 0; wake_done !== 1'b1 && n < 200; n++) tick();
        {irq_any, irq_rtc, irq_port} = 3'h0;
        cmp("wake_done", 16'h0001, wake_done);
        cmp("mode after wake", 16'(lpm_seq_pkg::mode_active), 16'(cur_mode));
        tick();
    endtask
    task automatic t_wake;
        enter(lpm_seq_pkg::mode_lpm3, 1'b0);
        irq_any = 1;
        wait_wake(n_set);
        cmp("wake time", lpm_seq_pkg::wake_lpm_cycles + 16'h0001, 16'(n_set));
        mem(1'b1, 1'b0);
        cmp("mem_inactive", 16'h0000, mem_inactive);
        enter(lpm_seq_pkg::mode_lpm2, 1'b1);
        irq_any = 1;
        wait_wake(n_clr);
        cmp("wake extension", lpm_seq_pkg::wake_mem_cycles, 16'(n_clr - n_set));
    endtask
    task automatic t_shut;
        enter(lpm_seq_pkg::mode_full_shutdown, 1'b0);
        irq_any = 1;
        tick(30);
        cmp("shutdown held", 16'(lpm_seq_pkg::mode_full_shutdown), 16'(cur_mode));
        irq_port = 1;
        wait_wake(n_set);
        enter(lpm_seq_pkg::mode_shutdown_with_clock, 1'b1);
        irq_rtc = 1;
        wait_wake(n_clr);
    endtask
    task automatic t_wdt;
        mem(1'b0, 1'b0);
        cmp("mem_inactive", 16'h0001, mem_inactive);
        enter(lpm_seq_pkg::mode_lpm4, 1'b0);
        wdt_soft_reset = 1;
        tick();
        wdt_soft_reset = 0;
        cmp("soft_reset", 16'h0001, soft_reset);
        tick(2);
        cmp("mem bits", 16'h0003, {mem_power_enable_bit, mem_lowpower_power_bit});
        for (int i = 0; i < 2; i++) begin
            {wdt_ctl_password, wdt_ctl_write} = {lpm_seq_pkg::wdt_password ^ 8'(i), 1'b1};
            tick();
            wdt_ctl_write = 0;
            cmp("password soft_reset", 16'(i), soft_reset);
            tick(2);
        end
    endtask
    task automatic t_pins;
        for (int i = 0; i < 4; i++) begin
            {reset_pin_resistor_enable_wr, reset_pin_resistor_direction_wr} = 2'(i);
            pin_cfg_write = 1;
            tick();
            pin_cfg_write = 0;
            tick();
            cmp("pull-down", 16'(i >> 1), test_twowire_clock_pin_pulldown_en);
            cmp("pull enable", 16'(i >> 1), reset_pin_pull_en);
            cmp("pull up", 16'(i & 1), reset_pin_pull_up);
        end
    endtask
    task automatic t_req;
        logic [7:0] pat [7] = '{8'h80, 8'h52, 8'h42, 8'h0a, 8'h06, 8'h01, 8'h00};
        logic [1:0] res [7] = '{2'h3, 2'h2, 2'h0, 2'h1, 2'h1, 2'h1, 2'h0};
        for (int i = 0; i < 7; i++) begin
            want = pat[i];
            tick(5);
            cmp("clock requests", {14'h0000, res[i]},
                {14'h0000, module_oscillator_clock_req, subsystem_clock_req});
        end
        want_cpu = 1;
        tick(3);
        cmp("cpu clock request", 16'h0001, {15'h0000, subsystem_clock_req});
        want_cpu = 0;
        tick(3);
        cmp("cpu request removed", 16'h0000, {15'h0000, subsystem_clock_req});
    endtask
    // reset, then the scenarios in turn
    initial begin
        tick(6);
        resetn = 1;
        tick();
        cmp("reset mode", 16'(lpm_seq_pkg::mode_active), 16'(cur_mode));
        cmp("reset bits", 16'h1f, {mem_power_enable_bit, mem_lowpower_power_bit,
            reset_pin_pull_en, reset_pin_pull_up, test_twowire_clock_pin_pulldown_en});
        t_wake();
        t_shut();
        t_wdt();
        t_pins();
        t_req();
        stop_test();
    end
    // watchdog against a hang
    initial begin
        #100us;
        err_count++;
        stop_test();
    end
endmodule
`default_nettype wire
